//--- include/pst_pkg.sv
// constants, register map and types for the secondary time base block
package pst_pkg;
   // ==========================================================
   // clock
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;

   // ==========================================================
   // register bus
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 32;
   localparam logic [7:0]  OFS_PERIOD     = 8'h00;
   localparam logic [7:0]  OFS_COMPARE    = 8'h04;
   localparam logic [7:0]  OFS_IO_CONTROL = 8'h08;
   localparam logic [7:0]  OFS_TB_CONTROL = 8'h0C;
   localparam logic [7:0]  OFS_UNLOCK_KEY = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0]  OFS_IRQ_MASK   = 8'h18;
   localparam logic [7:0]  OFS_COUNT      = 8'h1C;

   // ==========================================================
   // time base
   localparam int          TB_W           = 16;
   localparam int          PRE_W          = 3;
   localparam int          PRE_CNT_W      = 7;
   localparam logic [15:0] PERIOD_RST     = 16'h4020;
   localparam logic [15:0] PERIOD_MIN     = 16'h0008;
   localparam logic [15:0] COMPARE_RST    = 16'h0000;
   localparam logic [7:0]  PRE_ONE        = 8'h01;
   localparam logic [15:0] CNT_ONE        = 16'h0001;
   localparam logic [15:0] CNT_ZERO       = 16'h0000;

   // ==========================================================
   // time base control layout
   localparam int          TBC_ENABLE_BIT = 15;
   localparam int          TBC_PRE_LSB    = 4;
   localparam logic [31:0] TBC_RST        = 32'h0000_0000;

   // ==========================================================
   // generator io control layout
   localparam logic [31:0] IOCTL_RST      = 32'h0070_0000;
   localparam logic [31:0] IOCTL_MASK     = 32'h3F7F_FFFF;

   // ==========================================================
   // unlock keys
   localparam logic [15:0] KEY_FIRST      = 16'hABCD;
   localparam logic [15:0] KEY_SECOND     = 16'h4321;

   // ==========================================================
   // interrupt sources
   localparam int          IRQ_W          = 2;
   localparam int          IRQ_EVENT      = 0;
   localparam int          IRQ_WRAP       = 1;
   localparam logic [1:0]  IRQ_RST        = 2'h0;

   typedef enum logic [1:0] {
      PST_LOCKED = 2'b00,
      PST_KEY1   = 2'b01,
      PST_OPEN   = 2'b10
   } pst_lock_e;
endpackage

//--- include/pst_tb_if.sv
// link between the register side and the time base counter
`timescale 1ns/1ns
interface pst_tb_if;
   logic        enable;
   logic [2:0]  prescale;
   logic [15:0] period;
   logic [15:0] compare;
   logic [15:0] count;
   logic        event_hit;
   logic        wrap;

   modport ctrl (output enable, prescale, period, compare,
                 input  count, event_hit, wrap);
   modport core (input  enable, prescale, period, compare,
                 output count, event_hit, wrap);
endinterface

//--- rtl/pst_timebase.sv
// secondary time base: prescaler, period counter and compare match
`timescale 1ns/1ns
module pst_timebase (
   input wire logic clk,      // system clock
   input wire logic reset,    // async reset, active high
   pst_tb_if.core   tb        // control in, count and strobes out
);
   // ==========================================================
   // prescaler and counter
   logic [6:0]  pre_cnt;
   logic [6:0]  next_pre_cnt;
   logic [6:0]  pre_top;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [15:0] eff_period;
   logic [15:0] last_cnt;
   logic        tick;
   logic        at_end;

   always_comb begin
      // short periods are stretched, never honoured
      eff_period = (tb.period < pst_pkg::PERIOD_MIN) ?
                   pst_pkg::PERIOD_MIN : tb.period;
      last_cnt   = eff_period - pst_pkg::CNT_ONE;
      // ratio 1:1 makes one count per system clock
      pre_top    = 7'((pst_pkg::PRE_ONE << tb.prescale) -
                      pst_pkg::PRE_ONE);
      // >= also recovers when the ratio is lowered mid-count
      tick       = tb.enable && (pre_cnt >= pre_top);
      // >= so a period shrunk mid-cycle wraps at once
      at_end     = cnt >= last_cnt;
      next_pre_cnt = '0;
      next_cnt     = pst_pkg::CNT_ZERO;
      if (tb.enable) begin
         next_pre_cnt = tick ? '0 : pre_cnt + 7'h01;
         next_cnt     = cnt;
         if (tick) begin
            next_cnt = at_end ? pst_pkg::CNT_ZERO
                              : cnt + pst_pkg::CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pre_cnt <= '0;
         cnt     <= 16'h0000;
      end else begin
         pre_cnt <= next_pre_cnt;
         cnt     <= next_cnt;
      end
   end

   assign tb.count     = cnt;
   assign tb.wrap      = tick && at_end;
   assign tb.event_hit = tick && (cnt == tb.compare);

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_wrap_restart;
      tb.wrap |=> (cnt == pst_pkg::CNT_ZERO);
   endproperty
   a_wrap_restart: assert property (p_wrap_restart)
      else $error("counter did not restart after wrap");

   property p_min_period;
      tb.wrap |-> (cnt >= 16'h0007);
   endproperty
   a_min_period: assert property (p_min_period)
      else $error("period shorter than eight counts");

   property p_disabled_hold;
      !tb.enable |=> (cnt == pst_pkg::CNT_ZERO) && (pre_cnt == 7'h00);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("counter moved while disabled");

   property p_fine_step;
      tb.enable && (tb.prescale == 3'h0) && !at_end &&
      $stable(tb.enable) ##0 $stable(tb.prescale)
      |=> (cnt == $past(cnt) + 16'h0001);
   endproperty
   a_fine_step: assert property (p_fine_step)
      else $error("1:1 prescale did not step every clock");

   property p_pre_four;
      tb.enable && (tb.prescale == 3'h2) && tick ##1
      (tb.enable && tb.prescale == 3'h2) [*3]
      |-> !tick;
   endproperty
   a_pre_four: assert property (p_pre_four)
      else $error("1:4 prescale ticked early");

   c_short_wrap: cover property (tb.wrap && tb.period < 16'h0008);
endmodule

//--- rtl/pst_secondary_timebase.sv
// secondary time base top: register file, unlock, trigger and interrupt
// How it works
// - 16-bit period value sets cycle length
// - finest period step is one system clock
// - period below eight runs as eight
// - frequency is clock over period times prescale
// - period and compare upper halves read zero, ignore writes
// - compare value read/write, zero after reset
// - special-event trigger starts converter, time-aligned
// - trigger placed anywhere within the period
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module pst_secondary_timebase (
   input  wire logic        clk,         // system clock, 20 MHz
   input  wire logic        reset,       // async reset, active high
   input  wire logic [7:0]  bus_addr,    // register byte address
   input  wire logic [31:0] bus_wdata,   // write data
   input  wire logic        bus_write,   // write strobe
   input  wire logic        bus_read,    // read strobe
   output logic      [31:0] bus_rdata,   // read data, cycle after read
   input  wire logic        config_lock, // lock pin, high = keys needed
   output logic             adc_trigger, // start of conversion pulse
   output logic             irq,         // level interrupt
   output logic [31:0]      io_control   // generator io fields
);
   // ==========================================================
   // lock pin synchroniser
   logic lock_meta;
   logic lock_sync;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lock_meta <= 1'b1;
         lock_sync <= 1'b1;
      end else begin
         lock_meta <= config_lock;
         lock_sync <= lock_meta;
      end
   end

   // ==========================================================
   // address decode
   logic wr_period;
   logic wr_compare;
   logic wr_ioctl;
   logic wr_tbc;
   logic wr_key;
   logic wr_status;
   logic wr_mask;
   logic any_access;

   always_comb begin
      wr_period  = bus_write && (bus_addr == pst_pkg::OFS_PERIOD);
      wr_compare = bus_write && (bus_addr == pst_pkg::OFS_COMPARE);
      wr_ioctl   = bus_write && (bus_addr == pst_pkg::OFS_IO_CONTROL);
      wr_tbc     = bus_write && (bus_addr == pst_pkg::OFS_TB_CONTROL);
      wr_key     = bus_write && (bus_addr == pst_pkg::OFS_UNLOCK_KEY);
      wr_status  = bus_write && (bus_addr == pst_pkg::OFS_IRQ_STATUS);
      wr_mask    = bus_write && (bus_addr == pst_pkg::OFS_IRQ_MASK);
      any_access = bus_write || bus_read;
   end

   // ==========================================================
   // unlock sequence
   pst_pkg::pst_lock_e lock_state;
   pst_pkg::pst_lock_e next_lock_state;
   logic               ioctl_open;

   always_comb begin
      // every access, reads included, breaks a sequence in progress
      next_lock_state = lock_state;
      if (any_access) begin
         case (lock_state)
            pst_pkg::PST_LOCKED: begin
               next_lock_state = (wr_key &&
                  bus_wdata[15:0] == pst_pkg::KEY_FIRST) ?
                  pst_pkg::PST_KEY1 : pst_pkg::PST_LOCKED;
            end
            pst_pkg::PST_KEY1: begin
               next_lock_state = (wr_key &&
                  bus_wdata[15:0] == pst_pkg::KEY_SECOND) ?
                  pst_pkg::PST_OPEN : pst_pkg::PST_LOCKED;
            end
            pst_pkg::PST_OPEN: begin
               next_lock_state = (wr_key &&
                  bus_wdata[15:0] == pst_pkg::KEY_FIRST) ?
                  pst_pkg::PST_KEY1 : pst_pkg::PST_LOCKED;
            end
            default: begin
               next_lock_state = pst_pkg::PST_LOCKED;
            end
         endcase
      end
      ioctl_open = !lock_sync || (lock_state == pst_pkg::PST_OPEN);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lock_state <= pst_pkg::PST_LOCKED;
      end else begin
         lock_state <= next_lock_state;
      end
   end

   // ==========================================================
   // configuration registers
   logic [15:0] period;
   logic [15:0] compare;
   logic [31:0] tb_control;
   logic [15:0] next_period;
   logic [15:0] next_compare;
   logic [31:0] next_tb_control;
   logic [31:0] next_io_control;
   logic [31:0] tbc_mask;

   always_comb begin
      tbc_mask = (32'h0000_0001 << pst_pkg::TBC_ENABLE_BIT) |
                 (32'h0000_0007 << pst_pkg::TBC_PRE_LSB);
      next_period     = period;
      next_compare    = compare;
      next_tb_control = tb_control;
      next_io_control = io_control;
      // period and compare upper halves are simply not stored
      if (wr_period) begin
         next_period = bus_wdata[15:0];
      end
      if (wr_compare) begin
         next_compare = bus_wdata[15:0];
      end
      if (wr_tbc) begin
         next_tb_control = bus_wdata & tbc_mask;
      end
      // a locked write is dropped silently, as on the real pins
      if (wr_ioctl && ioctl_open) begin
         next_io_control = bus_wdata & pst_pkg::IOCTL_MASK;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         period     <= pst_pkg::PERIOD_RST;
         compare    <= pst_pkg::COMPARE_RST;
         tb_control <= pst_pkg::TBC_RST;
         io_control <= pst_pkg::IOCTL_RST;
      end else begin
         period     <= next_period;
         compare    <= next_compare;
         tb_control <= next_tb_control;
         io_control <= next_io_control;
      end
   end

   // ==========================================================
   // time base
   pst_tb_if tb ();

   assign tb.enable   = tb_control[pst_pkg::TBC_ENABLE_BIT];
   assign tb.prescale = tb_control[pst_pkg::TBC_PRE_LSB +: 3];
   assign tb.period   = period;
   assign tb.compare  = compare;

   pst_timebase u_timebase (
      .clk   (clk),
      .reset (reset),
      .tb    (tb)
   );

   // ==========================================================
   // trigger and interrupt
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [1:0] next_irq_status;
   logic [1:0] next_irq_mask;
   logic [1:0] irq_events;
   logic       next_trigger;

   always_comb begin
      next_trigger = tb.event_hit;
      irq_events   = {tb.wrap, tb.event_hit};
      next_irq_mask = irq_mask;
      if (wr_mask) begin
         next_irq_mask = bus_wdata[1:0];
      end
      // set wins over a clear in the same cycle
      next_irq_status = irq_status;
      if (wr_status) begin
         next_irq_status = irq_status & ~bus_wdata[1:0];
      end
      next_irq_status = next_irq_status | irq_events;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         adc_trigger <= 1'b0;
         irq_status  <= pst_pkg::IRQ_RST;
         irq_mask    <= pst_pkg::IRQ_RST;
      end else begin
         adc_trigger <= next_trigger;
         irq_status  <= next_irq_status;
         irq_mask    <= next_irq_mask;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ==========================================================
   // read port
   logic [31:0] next_rdata;

   always_comb begin
      // data stand one cycle only; zero otherwise and when unmapped
      next_rdata = 32'h0000_0000;
      if (bus_read) begin
         case (bus_addr)
            pst_pkg::OFS_PERIOD:     next_rdata = {16'h0000, period};
            pst_pkg::OFS_COMPARE:    next_rdata = {16'h0000, compare};
            pst_pkg::OFS_IO_CONTROL: next_rdata = io_control;
            pst_pkg::OFS_TB_CONTROL: next_rdata = tb_control;
            pst_pkg::OFS_IRQ_STATUS: next_rdata = {30'h0, irq_status};
            pst_pkg::OFS_IRQ_MASK:   next_rdata = {30'h0, irq_mask};
            pst_pkg::OFS_COUNT:      next_rdata = {16'h0000, tb.count};
            default:                 next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_rdata <= 32'h0000_0000;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_trigger_cause;
      tb.event_hit |=> adc_trigger;
   endproperty
   a_trigger_cause: assert property (p_trigger_cause)
      else $error("compare match did not raise trigger");

   property p_trigger_match;
      adc_trigger |-> $past(tb.count) == $past(compare);
   endproperty
   a_trigger_match: assert property (p_trigger_match)
      else $error("trigger without count equal to compare");

   property p_upper_zero;
      bus_read && (bus_addr == pst_pkg::OFS_PERIOD ||
                   bus_addr == pst_pkg::OFS_COMPARE)
      |=> bus_rdata[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper half of period or compare not zero");

   property p_period_store;
      wr_period |=> period == $past(bus_wdata[15:0]);
   endproperty
   a_period_store: assert property (p_period_store)
      else $error("period write not stored");

   property p_lock_block;
      wr_ioctl && lock_sync && lock_state != pst_pkg::PST_OPEN
      |=> $stable(io_control);
   endproperty
   a_lock_block: assert property (p_lock_block)
      else $error("locked io control accepted a write");

   property p_status_sticky;
      // a clear in the event's own cycle must lose
      tb.event_hit ||
      (irq_status[0] && !(wr_status && bus_wdata[0]))
      |=> irq_status[0];
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("event status bit not held");

   property p_read_one_cycle;
      !bus_read |=> bus_rdata == 32'h0000_0000;
   endproperty
   a_read_one_cycle: assert property (p_read_one_cycle)
      else $error("read data stood without a read");

   c_trigger:    cover property (adc_trigger);
   c_unlock:     cover property (wr_ioctl && lock_sync &&
                                 lock_state == pst_pkg::PST_OPEN);
   c_irq_clear:  cover property (irq ##1 !irq);
endmodule

//--- sim/pst_adc_model.sv
// converter start input stand-in: counts starts and measures their spacing
`timescale 1ns/1ns
module pst_adc_model (
   input  wire logic clk,          // system clock
   input  wire logic reset,        // async reset, active high
   input  wire logic start_conv,   // conversion start pulse
   output int        conv_count,   // starts seen since reset
   output int        last_gap,     // cycles between the last two starts
   output logic      long_pulse    // a start was held over two cycles
);
   // ==========================================================
   // start tracking
   // sampling itself is not modelled, only when starts arrive
   int   since;
   logic prev;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         conv_count <= 0;
         last_gap   <= 0;
         since      <= 0;
         prev       <= 1'b0;
         long_pulse <= 1'b0;
      end else begin
         prev  <= start_conv;
         since <= since + 1;
         if (start_conv) begin
            conv_count <= conv_count + 1;
            last_gap   <= since + 1;
            since      <= 0;
         end
         if (start_conv && prev) begin
            long_pulse <= 1'b1;
         end
      end
   end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the secondary time base block
`timescale 1ns/1ns
module tb_top;
   logic        clk;
   logic        reset;
   logic [7:0]  bus_addr;
   logic [31:0] bus_wdata;
   logic        bus_write;
   logic        bus_read;
   logic [31:0] bus_rdata;
   logic        config_lock;
   logic        adc_trigger;
   logic        irq;
   logic [31:0] io_control;
   int          conv_count;
   int          last_gap;
   logic        long_pulse;
   int          err_total;
   int          total_checks;
   int          cycles;
   int          d0;
   int          d7;
   int          n;

   pst_secondary_timebase dut_u (
      .clk         (clk),
      .reset       (reset),
      .bus_addr    (bus_addr),
      .bus_wdata   (bus_wdata),
      .bus_write   (bus_write),
      .bus_read    (bus_read),
      .bus_rdata   (bus_rdata),
      .config_lock (config_lock),
      .adc_trigger (adc_trigger),
      .irq         (irq),
      .io_control  (io_control)
   );

   pst_adc_model adc_u (
      .clk        (clk),
      .reset      (reset),
      .start_conv (adc_trigger),
      .conv_count (conv_count),
      .last_gap   (last_gap),
      .long_pulse (long_pulse)
   );

   // ==========================================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // longest case is the 2500-cycle wait with compare past the period, plus setup
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end

   // ==========================================================
   // compare and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask

   task automatic chk_n(input int got, input int exp, input string what);
      total_checks++;
      if (got != exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %0d", $time, what, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge clk);
      bus_write <= 1'b0;
      // step off the edge so callers see the registers it updated
      #1;
   endtask

   // read data stand only in the cycle after the read edge
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
      @(posedge clk);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clk);
      bus_read <= 1'b0;
      #1;
      chk(bus_rdata, exp, what);
   endtask

   task automatic wait_trig(output int k);
      int c0;
      c0 = conv_count;
      k = 0;
      while (conv_count == c0 && k < 2500) begin
         @(posedge clk);
         k++;
      end
   endtask

   task automatic cfg(input logic [15:0] per, input logic [15:0] cmp,
                      input logic [2:0] pre);
      wr(pst_pkg::OFS_TB_CONTROL, 32'h0000_0000);
      wr(pst_pkg::OFS_PERIOD, {16'h0000, per});
      wr(pst_pkg::OFS_COMPARE, {16'h0000, cmp});
      wr(pst_pkg::OFS_TB_CONTROL, {16'h0000, 1'b1, 8'h00, pre, 4'h0});
   endtask

   task automatic gap_case(input logic [15:0] per, input logic [15:0] cmp,
                           input logic [2:0] pre, input int exp);
      cfg(per, cmp, pre);
      wait_trig(n);
      wait_trig(n);
      chk_n(last_gap, exp, "trigger spacing");
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs;
      rd_chk(pst_pkg::OFS_PERIOD, {16'h0000, pst_pkg::PERIOD_RST}, "per");
      rd_chk(pst_pkg::OFS_COMPARE, 32'h0000_0000, "cmp rst");
      rd_chk(pst_pkg::OFS_IO_CONTROL, pst_pkg::IOCTL_RST, "io rst");
      wr(8'h20, 32'h0000_00FF);
      rd_chk(8'h20, 32'h0000_0000, "unmapped");
      wr(pst_pkg::OFS_PERIOD, 32'hFFFF_0011);
      rd_chk(pst_pkg::OFS_PERIOD, 32'h0000_0011, "per upper");
      wr(pst_pkg::OFS_COMPARE, 32'hA5A5_1234);
      rd_chk(pst_pkg::OFS_COMPARE, 32'h0000_1234, "cmp upper");
      wr(pst_pkg::OFS_COUNT, 32'h0000_0005);
      rd_chk(pst_pkg::OFS_COUNT, 32'h0000_0000, "count idle");
   endtask

   task automatic t_timing;
      gap_case(16'h0003, 16'h0000, 3'h0, 8);
      gap_case(16'h0009, 16'h0002, 3'h0, 9);
      gap_case(16'h000A, 16'h0004, 3'h1, 20);
      gap_case(16'h0008, 16'h0001, 3'h2, 32);
      gap_case(16'h0008, 16'h0007, 3'h7, 1024);
      // offset of the first start follows the compare value exactly
      cfg(16'h0003, 16'h0000, 3'h0);
      wait_trig(d0);
      cfg(16'h0003, 16'h0007, 3'h0);
      wait_trig(d7);
      chk_n(d7 - d0, 7, "trigger position");
      cfg(16'h0003, 16'h0008, 3'h0);
      wait_trig(n);
      chk_n(n, 2500, "compare past period");
      chk({31'h0, long_pulse}, 32'h0000_0000, "start width");
   endtask

   task automatic t_irq;
      wr(pst_pkg::OFS_TB_CONTROL, 32'h0000_0000);
      wr(pst_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      wr(pst_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
      cfg(16'h0008, 16'h0003, 3'h0);
      wait_trig(n);
      repeat (10) @(posedge clk);
      wr(pst_pkg::OFS_TB_CONTROL, 32'h0000_0000);
      rd_chk(pst_pkg::OFS_IRQ_STATUS, 32'h0000_0003, "status");
      chk({31'h0, irq}, 32'h0000_0000, "irq masked");
      wr(pst_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001, "irq event");
      wr(pst_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
      rd_chk(pst_pkg::OFS_IRQ_STATUS, 32'h0000_0002, "status wrap");
      wr(pst_pkg::OFS_IRQ_MASK, 32'h0000_0002);
      chk({31'h0, irq}, 32'h0000_0001, "irq wrap");
      wr(pst_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
      chk({31'h0, irq}, 32'h0000_0000, "irq wrap clr");
   endtask

   task automatic t_lock;
      rd_chk(pst_pkg::OFS_TB_CONTROL, 32'h0000_0000, "run off");
      config_lock <= 1'b1;
      repeat (3) @(posedge clk);
      wr(pst_pkg::OFS_IO_CONTROL, 32'h0000_1234);
      rd_chk(pst_pkg::OFS_IO_CONTROL, pst_pkg::IOCTL_RST, "no keys");
      wr(pst_pkg::OFS_UNLOCK_KEY, {16'h0000, pst_pkg::KEY_FIRST});
      rd_chk(pst_pkg::OFS_UNLOCK_KEY, 32'h0000_0000, "key read");
      wr(pst_pkg::OFS_UNLOCK_KEY, {16'h0000, pst_pkg::KEY_SECOND});
      wr(pst_pkg::OFS_IO_CONTROL, 32'h0000_1234);
      rd_chk(pst_pkg::OFS_IO_CONTROL, pst_pkg::IOCTL_RST, "broken");
      wr(pst_pkg::OFS_UNLOCK_KEY, {16'h0000, pst_pkg::KEY_FIRST});
      wr(pst_pkg::OFS_UNLOCK_KEY, {16'h0000, pst_pkg::KEY_SECOND});
      wr(pst_pkg::OFS_IO_CONTROL, 32'hFFFF_FFFF);
      rd_chk(pst_pkg::OFS_IO_CONTROL, pst_pkg::IOCTL_MASK, "keyed");
      chk(io_control, pst_pkg::IOCTL_MASK, "io port");
      wr(pst_pkg::OFS_IO_CONTROL, 32'h0000_0000);
      rd_chk(pst_pkg::OFS_IO_CONTROL, pst_pkg::IOCTL_MASK, "relock");
      config_lock <= 1'b0;
      repeat (3) @(posedge clk);
      wr(pst_pkg::OFS_IO_CONTROL, 32'h1555_5555);
      rd_chk(pst_pkg::OFS_IO_CONTROL, 32'h1555_5555 & pst_pkg::IOCTL_MASK,
             "open");
   endtask

   // ==========================================================
   // closing report
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      reset        = 1'b1;
      bus_addr     = 8'h00;
      bus_wdata    = 32'h0000_0000;
      bus_write    = 1'b0;
      bus_read     = 1'b0;
      config_lock  = 1'b0;
      err_total    = 0;
      total_checks = 0;
      cycles       = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_timing();
      t_irq();
      t_lock();
      conclude();
   end
endmodule
